// *** cmm_pkg.sv ***
// shared constants and carrier types for the core memory map and interrupt control
package cmm_pkg;

    // ----------------------------------------
    // program space
    // ----------------------------------------
    localparam int CMM_PC_W = 13;
    localparam logic [12:0] CMM_RESET_VEC = 13'h0000;
    localparam logic [12:0] CMM_IRQ_VEC = 13'h0004;
    localparam logic [12:0] CMM_PC_STEP = 13'h0001;
    localparam logic [12:0] CMM_MASK_1K = 13'h03ff;
    localparam logic [12:0] CMM_MASK_2K = 13'h07ff;
    localparam logic [12:0] CMM_MASK_4K = 13'h0fff;
    localparam logic [1:0] CMM_SIZE_1K = 2'h0;
    localparam logic [1:0] CMM_SIZE_2K = 2'h1;

    // ----------------------------------------
    // data space
    // ----------------------------------------
    localparam logic [6:0] CMM_SFR_END = 7'h20;
    localparam logic [6:0] CMM_INTCTL_OFS = 7'h0b;
    localparam logic [6:0] CMM_COMMON_LO = 7'h70;
    localparam logic [6:0] CMM_B2_SMALL_END = 7'h50;
    localparam logic [7:0] CMM_GPR_OFS = 8'h20;
    localparam logic [7:0] CMM_BASE_B0 = 8'h00;
    localparam logic [7:0] CMM_BASE_COMMON = 8'h50;
    localparam logic [7:0] CMM_BASE_B1 = 8'h60;
    localparam logic [7:0] CMM_BASE_B2 = 8'hb0;
    localparam int CMM_RAM_DEPTH = 256;

    // ----------------------------------------
    // interrupt control fields
    // ----------------------------------------
    localparam int CMM_GIE = 7;
    localparam int CMM_PERIPHERAL_IRQ_ENABLE = 6;
    localparam int CMM_TIMER_ZERO_OVERFLOW_ENABLE = 5;
    localparam int CMM_EXTIE = 4;
    localparam int CMM_PCHIE = 3;
    localparam int CMM_TIMER_ZERO_OVERFLOW_FLAG = 2;
    localparam int CMM_EXTIF = 1;
    localparam int CMM_PCHIF = 0;
    localparam logic [7:0] CMM_INTCTL_RST = 8'h00;

    typedef enum logic [1:0] {
        CMM_K_NONE = 2'b00,
        CMM_K_SFR = 2'b01,
        CMM_K_INTCTL = 2'b10,
        CMM_K_RAM = 2'b11
    } cmm_kind_e;

    typedef struct packed {
        cmm_kind_e kind;
        logic [7:0] idx;
    } cmm_dec_s;

    typedef struct packed {
        logic [CMM_RAM_DEPTH-1:0][7:0] ram;
        logic [12:0] pc;
        logic [12:0] prog_addr;
        logic [7:0] intctl;
        logic [7:0] rdata;
        logic sfr_hit;
        logic irq;
        logic [3:0] pins_prev;
        logic pins_ok;
    } cmm_state_s;

    localparam cmm_state_s CMM_STATE_RST = '0;

endpackage

// *** cmm_top.sv ***
// program/data address decode, general RAM and the interrupt control register
`timescale 1ns/1ps
module cmm_top
    import cmm_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic PC_INC,
    input wire logic PC_LOAD,
    input wire logic [12:0] PC_LOAD_VAL,
    input wire logic IRQ_ACK,
    input wire logic [1:0] PROG_SIZE_SEL,
    input wire logic LARGE_RAM,
    input wire logic BANK_SEL_HIGH,
    input wire logic BANK_SEL_LOW,
    input wire logic [6:0] DATA_DIR_ADDR,
    input wire logic DATA_IND,
    input wire logic IND_BANK_HIGH,
    input wire logic [7:0] INDIRECT_POINTER,
    input wire logic DATA_RD,
    input wire logic DATA_WR,
    input wire logic [7:0] DATA_WDATA,
    input wire logic TIMER_ZERO_OVF,
    input wire logic EXT_IRQ_EVENT,
    input wire logic [3:0] UPPER_PORT_PINS,
    input wire logic PERIPH_IRQ_PEND,
    output logic [12:0] PROG_ADDR,
    output logic [7:0] DATA_RDATA,
    output logic DATA_SFR_HIT,
    output logic [7:0] INTERRUPT_CONTROL,
    output logic IRQ_REQ
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [12:0] prog_mask(input logic [1:0] sel);
        logic [12:0] m;
        m = CMM_MASK_4K;
        if (sel == CMM_SIZE_1K) begin
            m = CMM_MASK_1K;
        end else if (sel == CMM_SIZE_2K) begin
            m = CMM_MASK_2K;
        end
        return m;
    endfunction

    // maps a 9-bit bank:offset address onto the physical RAM index
    function automatic cmm_dec_s data_decode(input logic [8:0] a, input logic big);
        cmm_dec_s d;
        logic [6:0] o;
        logic [7:0] rel;
        o = a[6:0];
        rel = {1'b0, o} - CMM_GPR_OFS;
        d.kind = CMM_K_NONE;
        d.idx = 8'h00;
        if (o < CMM_SFR_END) begin
            d.kind = (o == CMM_INTCTL_OFS) ? CMM_K_INTCTL : CMM_K_SFR;
        end else if (o >= CMM_COMMON_LO) begin
            // one shared window, whatever the bank
            d.kind = CMM_K_RAM;
            d.idx = CMM_BASE_COMMON + {4'h0, o[3:0]};
        end else begin
            unique case (a[8:7])
                2'b00: begin
                    d.kind = CMM_K_RAM;
                    d.idx = CMM_BASE_B0 + rel;
                end
                2'b01: begin
                    d.kind = CMM_K_RAM;
                    d.idx = CMM_BASE_B1 + rel;
                end
                2'b10: begin
                    if (big || o < CMM_B2_SMALL_END) begin
                        d.kind = CMM_K_RAM;
                        d.idx = CMM_BASE_B2 + rel;
                    end
                end
                2'b11: begin
                    d.kind = CMM_K_NONE;
                end
            endcase
        end
        return d;
    endfunction

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic [1:0] rst_sync;
    logic rst_n;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    assign rst_n = rst_sync[1];

    // ----------------------------------------
    // state
    // ----------------------------------------
    cmm_state_s s_reg;
    cmm_state_s s_next;
    cmm_dec_s dec;
    logic [8:0] full_addr;
    logic wr_intctl;
    logic [2:0] pend;

    // bank number is high select times two plus low select
    assign full_addr = DATA_IND ? {IND_BANK_HIGH, INDIRECT_POINTER}
                                : {BANK_SEL_HIGH, BANK_SEL_LOW, DATA_DIR_ADDR};
    assign dec = data_decode(full_addr, LARGE_RAM);
    assign wr_intctl = DATA_WR && dec.kind == CMM_K_INTCTL;

    always_comb begin
        s_next = s_reg;
        s_next.rdata = 8'h00;
        s_next.sfr_hit = 1'b0;
        pend = 3'b000;

        if (IRQ_ACK) begin
            s_next.pc = CMM_IRQ_VEC;
        end else if (PC_LOAD) begin
            s_next.pc = PC_LOAD_VAL;
        end else if (PC_INC) begin
            s_next.pc = s_reg.pc + CMM_PC_STEP;
        end
        s_next.prog_addr = s_next.pc & prog_mask(PROG_SIZE_SEL);

        if (DATA_WR) begin
            unique case (dec.kind)
                CMM_K_RAM: s_next.ram[dec.idx] = DATA_WDATA;
                CMM_K_INTCTL: s_next.intctl = DATA_WDATA;
                CMM_K_SFR: s_next.sfr_hit = 1'b1;
                CMM_K_NONE: s_next.sfr_hit = 1'b0;
            endcase
        end
        if (DATA_RD) begin
            unique case (dec.kind)
                CMM_K_RAM: s_next.rdata = s_reg.ram[dec.idx];
                CMM_K_INTCTL: s_next.rdata = s_reg.intctl;
                CMM_K_SFR: s_next.sfr_hit = 1'b1;
                CMM_K_NONE: s_next.rdata = 8'h00;
            endcase
        end

        // hardware sets land after the software write, so a set wins over a clear
        if (TIMER_ZERO_OVF) begin
            s_next.intctl[CMM_TIMER_ZERO_OVERFLOW_FLAG] = 1'b1;
        end
        if (EXT_IRQ_EVENT) begin
            s_next.intctl[CMM_EXTIF] = 1'b1;
        end
        // the first sample after reset has nothing to compare against
        if (s_reg.pins_ok && UPPER_PORT_PINS != s_reg.pins_prev) begin
            s_next.intctl[CMM_PCHIF] = 1'b1;
        end
        s_next.pins_prev = UPPER_PORT_PINS;
        s_next.pins_ok = 1'b1;

        pend[0] = s_next.intctl[CMM_TIMER_ZERO_OVERFLOW_ENABLE] && s_next.intctl[CMM_TIMER_ZERO_OVERFLOW_FLAG];
        pend[1] = s_next.intctl[CMM_EXTIE] && s_next.intctl[CMM_EXTIF];
        pend[2] = s_next.intctl[CMM_PCHIE] && s_next.intctl[CMM_PCHIF];
        s_next.irq = s_next.intctl[CMM_GIE]
                  && ((|pend) || (s_next.intctl[CMM_PERIPHERAL_IRQ_ENABLE] && PERIPH_IRQ_PEND));
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= CMM_STATE_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign PROG_ADDR = s_reg.prog_addr;
    assign DATA_RDATA = s_reg.rdata;
    assign DATA_SFR_HIT = s_reg.sfr_hit;
    assign INTERRUPT_CONTROL = s_reg.intctl;
    assign IRQ_REQ = s_reg.irq;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence intctl_write_s;
        wr_intctl && !TIMER_ZERO_OVF && !EXT_IRQ_EVENT;
    endsequence

    sequence intctl_shows_s(logic [7:0] v);
        INTERRUPT_CONTROL[7:3] == v[7:3];
    endsequence

    irq_vector_a: assert property (@(posedge CLK) disable iff (!rst_n)
        IRQ_ACK |=> s_reg.pc == CMM_IRQ_VEC && PROG_ADDR == CMM_IRQ_VEC)
        else $error("interrupt vector not taken");

    prog_wrap_a: assert property (@(posedge CLK) disable iff (!rst_n)
        PC_LOAD && !IRQ_ACK |=> PROG_ADDR == ($past(PC_LOAD_VAL) & prog_mask($past(PROG_SIZE_SEL))))
        else $error("program address not wrapped");

    intctl_mirror_a: assert property (@(posedge CLK) disable iff (!rst_n)
        intctl_write_s |=> intctl_shows_s($past(DATA_WDATA)))
        else $error("interrupt control write lost");

    timer_flag_a: assert property (@(posedge CLK) disable iff (!rst_n)
        TIMER_ZERO_OVF |=> INTERRUPT_CONTROL[CMM_TIMER_ZERO_OVERFLOW_FLAG] ##1 (INTERRUPT_CONTROL[CMM_TIMER_ZERO_OVERFLOW_FLAG]
            || $past(wr_intctl)))
        else $error("timer flag not set or cleared by hardware");

    ext_flag_a: assert property (@(posedge CLK) disable iff (!rst_n)
        EXT_IRQ_EVENT |=> INTERRUPT_CONTROL[CMM_EXTIF])
        else $error("external flag not set");

    port_flag_a: assert property (@(posedge CLK) disable iff (!rst_n)
        s_reg.pins_ok && UPPER_PORT_PINS != s_reg.pins_prev |=> INTERRUPT_CONTROL[CMM_PCHIF])
        else $error("port change flag not set");

    global_block_a: assert property (@(posedge CLK) disable iff (!rst_n)
        !INTERRUPT_CONTROL[CMM_GIE] |-> !IRQ_REQ)
        else $error("request raised with global enable off");

    periph_block_a: assert property (@(posedge CLK) disable iff (!rst_n)
        !INTERRUPT_CONTROL[CMM_PERIPHERAL_IRQ_ENABLE] && (INTERRUPT_CONTROL[5:3] & INTERRUPT_CONTROL[2:0]) == 3'h0
            |-> !IRQ_REQ)
        else $error("peripheral request passed with peripheral enable off");

    irq_raise_a: assert property (@(posedge CLK) disable iff (!rst_n)
        INTERRUPT_CONTROL[CMM_GIE] && INTERRUPT_CONTROL[CMM_TIMER_ZERO_OVERFLOW_ENABLE] && INTERRUPT_CONTROL[CMM_TIMER_ZERO_OVERFLOW_FLAG]
            |-> IRQ_REQ)
        else $error("enabled pending interrupt not requested");

    common_ram_a: assert property (@(posedge CLK) disable iff (!rst_n)
        (DATA_RD || DATA_WR) && full_addr[6:4] == 3'h7
            |-> dec.kind == CMM_K_RAM && dec.idx == CMM_BASE_COMMON + {4'h0, full_addr[3:0]})
        else $error("common window not shared");

    sequence sfr_access_s;
        (DATA_RD || DATA_WR) && full_addr[6:0] < CMM_SFR_END && full_addr[6:0] != CMM_INTCTL_OFS;
    endsequence

    // places with no RAM behind them must read back as zero
    sequence hole_read_s;
        DATA_RD && full_addr[6:0] >= CMM_SFR_END && full_addr[6:0] < CMM_COMMON_LO
            && (full_addr[8:7] == 2'b11 || (full_addr[8:7] == 2'b10 && !LARGE_RAM
            && full_addr[6:0] >= CMM_B2_SMALL_END));
    endsequence

    reset_state_a: assert property (@(posedge CLK)
        !rst_n |-> PROG_ADDR == CMM_RESET_VEC && INTERRUPT_CONTROL == CMM_INTCTL_RST)
        else $error("reset state not held");

    pc_step_a: assert property (@(posedge CLK) disable iff (!rst_n)
        PC_INC && !PC_LOAD && !IRQ_ACK |=> s_reg.pc == $past(s_reg.pc) + CMM_PC_STEP)
        else $error("program counter did not step");

    sfr_access_a: assert property (@(posedge CLK) disable iff (!rst_n)
        sfr_access_s |=> DATA_SFR_HIT && DATA_RDATA == 8'h00)
        else $error("special register access not flagged");

    access_idle_a: assert property (@(posedge CLK) disable iff (!rst_n)
        !DATA_RD && !DATA_WR |=> !DATA_SFR_HIT && DATA_RDATA == 8'h00)
        else $error("access answer outside its cycle");

    hole_read_a: assert property (@(posedge CLK) disable iff (!rst_n)
        hole_read_s |=> DATA_RDATA == 8'h00)
        else $error("unimplemented place read nonzero");

    intctl_read_a: assert property (@(posedge CLK) disable iff (!rst_n)
        DATA_RD && full_addr[6:0] == CMM_INTCTL_OFS
            |=> DATA_RDATA == $past(INTERRUPT_CONTROL))
        else $error("interrupt control read wrong");

    periph_raise_a: assert property (@(posedge CLK) disable iff (!rst_n)
        INTERRUPT_CONTROL[CMM_GIE] && INTERRUPT_CONTROL[CMM_PERIPHERAL_IRQ_ENABLE] && $past(PERIPH_IRQ_PEND)
            |-> IRQ_REQ)
        else $error("peripheral request not passed");

    ext_flag_hold_a: assert property (@(posedge CLK) disable iff (!rst_n)
        INTERRUPT_CONTROL[CMM_EXTIF] && !wr_intctl |=> INTERRUPT_CONTROL[CMM_EXTIF])
        else $error("external flag cleared by hardware");

endmodule

// *** cmm_core_model.sv ***
// processor core model: fetch control and byte accesses into the data space
`timescale 1ns/1ps
module cmm_core_model
    import cmm_pkg::*;
(
    input wire logic clk,
    output logic pc_load,
    output logic [12:0] pc_load_val,
    output logic irq_ack,
    output logic bank_high,
    output logic bank_low,
    output logic [6:0] dir_addr,
    output logic ind,
    output logic ind_high,
    output logic [7:0] pointer,
    output logic rd,
    output logic wr,
    output logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic sfr_hit
);
    initial begin
        {pc_load, pc_load_val, irq_ack, bank_high, bank_low, dir_addr} = '0;
        {ind, ind_high, pointer, rd, wr, wdata} = '0;
    end
    // called just after a falling edge; a read returns the byte of the next cycle
    task automatic access(input logic w, input logic mode, input logic [8:0] a,
                          input logic [7:0] d, output logic [8:0] q);
        ind = mode;
        {bank_high, bank_low, dir_addr} = a;
        {ind_high, pointer} = a;
        wdata = d;
        wr = w;
        rd = !w;
        @(negedge clk);
        q = {sfr_hit, rdata};
        {rd, wr} = '0;
        // released data, offset and pointer lines carry the inverse so nothing stale can pass for a match; bank selects keep their value
        wdata = ~d;
        dir_addr = ~a[6:0];
        pointer = ~a[7:0];
        @(negedge clk);
    endtask
    task automatic jump(input logic ack, input logic [12:0] v);
        irq_ack = ack;
        pc_load = !ack;
        pc_load_val = v;
        @(negedge clk);
        {irq_ack, pc_load} = '0;
        pc_load_val = ~v;
        repeat (2) @(negedge clk);
    endtask
endmodule

// *** tb.sv ***
// self-checking bench for the memory map and interrupt control block
`timescale 1ns/1ps
module tb;
    import cmm_pkg::*;
    logic CLK = 0;
    logic RESET_N = 0;
    logic PC_INC = 0;
    logic [1:0] PROG_SIZE_SEL = 2'h2;
    logic LARGE_RAM = 1;
    logic TIMER_ZERO_OVF = 0;
    logic EXT_IRQ_EVENT = 0;
    logic [3:0] UPPER_PORT_PINS = 4'h0;
    logic PERIPH_IRQ_PEND = 0;
    logic pl, ack, bh, bl, ind, ih, rd, wr, hit, irq;
    logic [12:0] plv, pa;
    logic [6:0] da;
    logic [7:0] ptr, wd, rdat, ic, d;
    logic [8:0] a, q;
    logic [16:0] seed = 17'd90767;
    int failures = 0;
    int n_checks = 0;

    always #12.5 CLK = ~CLK;

    cmm_core_model u_core (.clk(CLK), .pc_load(pl), .pc_load_val(plv), .irq_ack(ack),
        .bank_high(bh), .bank_low(bl), .dir_addr(da), .ind(ind), .ind_high(ih),
        .pointer(ptr), .rd(rd), .wr(wr), .wdata(wd), .rdata(rdat), .sfr_hit(hit));
    cmm_top u_cmm_top (.CLK(CLK), .RESET_N(RESET_N), .PC_INC(PC_INC), .PC_LOAD(pl),
        .PC_LOAD_VAL(plv), .IRQ_ACK(ack), .PROG_SIZE_SEL(PROG_SIZE_SEL),
        .LARGE_RAM(LARGE_RAM), .BANK_SEL_HIGH(bh), .BANK_SEL_LOW(bl), .DATA_DIR_ADDR(da),
        .DATA_IND(ind), .IND_BANK_HIGH(ih), .INDIRECT_POINTER(ptr), .DATA_RD(rd),
        .DATA_WR(wr), .DATA_WDATA(wd), .TIMER_ZERO_OVF(TIMER_ZERO_OVF),
        .EXT_IRQ_EVENT(EXT_IRQ_EVENT), .UPPER_PORT_PINS(UPPER_PORT_PINS),
        .PERIPH_IRQ_PEND(PERIPH_IRQ_PEND), .PROG_ADDR(pa), .DATA_RDATA(rdat),
        .DATA_SFR_HIT(hit), .INTERRUPT_CONTROL(ic), .IRQ_REQ(irq));

    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    function automatic logic [12:0] fold(input logic [12:0] v, input logic [1:0] sz);
        return v & (sz == 2'h0 ? 13'h03ff : sz == 2'h1 ? 13'h07ff : 13'h0fff);
    endfunction
    function automatic logic irq_exp(input logic [7:0] c, input logic p);
        return c[7] & ((c[5] & c[2]) | (c[4] & c[1]) | (c[3] & c[0]) | (c[6] & p));
    endfunction
    // unimplemented places read back zero; the top sixteen offsets are shared
    function automatic logic [7:0] ram_exp(input logic [8:0] x, input logic [7:0] v,
                                           input logic big);
        if (x[6:0] < 7'h20 || (x[8:7] == 2'h3 && x[6:4] != 3'h7)) return 8'h00;
        if (!big && x[8:7] == 2'h2 && (x[6:4] == 3'h5 || x[6:4] == 3'h6)) return 8'h00;
        return v;
    endfunction
    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic put(input logic [8:0] x, input logic [7:0] v);
        u_core.access(1'b1, seed[0], x, v, q);
        seed = lfsr(seed);
        chk(q, {x[6:0] < CMM_SFR_END && x[6:0] != CMM_INTCTL_OFS, 8'h00});
    endtask
    task automatic get(input logic [8:0] x, input logic [7:0] e);
        u_core.access(1'b0, seed[1], x, 8'h00, q);
        seed = lfsr(seed);
        chk(q, {x[6:0] < CMM_SFR_END && x[6:0] != CMM_INTCTL_OFS, e});
    endtask

    initial begin
        #100000;
        failures++;
        print_verdict();
    end

    initial begin
        repeat (3) @(negedge CLK);
        RESET_N = 1;
        repeat (4) @(negedge CLK);
        chk(ic, CMM_INTCTL_RST);
        chk(pa, CMM_RESET_VEC);
        $display("reset test done");
        for (int i = 0; i < 12; i++) begin
            PROG_SIZE_SEL = i[1:0];
            u_core.jump(1'b0, seed[12:0]);
            chk(pa, fold(seed[12:0], i[1:0]));
            seed = lfsr(seed);
        end
        PROG_SIZE_SEL = CMM_SIZE_1K;
        u_core.jump(1'b0, 13'h03ff);
        PC_INC = 1;
        @(negedge CLK);
        PC_INC = 0;
        repeat (2) @(negedge CLK);
        chk(pa, 13'h0000);
        u_core.jump(1'b1, 13'h1fff);
        chk(pa, CMM_IRQ_VEC);
        $display("program space test done");
        for (int i = 0; i < 8; i++) begin
            d = seed[15:8];
            PERIPH_IRQ_PEND = seed[5];
            put({seed[1:0], CMM_INTCTL_OFS}, d);
            get({seed[3:2], CMM_INTCTL_OFS}, d);
            chk(irq, irq_exp(d, PERIPH_IRQ_PEND));
        end
        PERIPH_IRQ_PEND = 0;
        put(9'h00b, 8'h00);
        {TIMER_ZERO_OVF, EXT_IRQ_EVENT} = 2'h3;
        UPPER_PORT_PINS = 4'h5;
        @(negedge CLK);
        {TIMER_ZERO_OVF, EXT_IRQ_EVENT} = 2'h0;
        repeat (3) @(negedge CLK);
        chk(ic, 8'h07);
        chk(irq, 1'b0);
        for (int k = 0; k < 3; k++) begin
            put(9'h08b, 8'h80 | 8'(8'h08 << k));
            TIMER_ZERO_OVF = (k == 2);
            EXT_IRQ_EVENT = (k == 1);
            if (k == 0) UPPER_PORT_PINS[3] = ~UPPER_PORT_PINS[3];
            @(negedge CLK);
            {TIMER_ZERO_OVF, EXT_IRQ_EVENT} = 2'h0;
            repeat (3) @(negedge CLK);
            chk(ic, 8'h80 | 8'(8'h09 << k));
            chk(irq, 1'b1);
            put(9'h10b, 8'h80);
            chk(ic, 8'h80);
            chk(irq, 1'b0);
        end
        $display("interrupt control test done");
        for (int i = 0; i < 40; i++) begin
            LARGE_RAM = seed[2];
            a = {seed[4:3], seed[11:5]};
            if (a[6:0] == CMM_INTCTL_OFS) a[6:0] = 7'h0c;
            d = seed[16:9];
            put(a, d);
            if (a[6:4] == 3'h7) a[8:7] = seed[1:0];
            get(a, ram_exp(a, d, LARGE_RAM));
        end
        $display("data space test done");
        print_verdict();
    end
endmodule
